// File: rtl/mtc_csr_top.sv
/*
 * misc timer and counter register bank: general purpose timer, host
 * word order control, free-running 25 MHz tick counter and dropped frame
 * tally, reached over the 16-bit sram-like host bus.
 * assumes frame_dropped is a one-cycle pulse from mclk logic; the timer
 * and dropped-frame events feed an interrupt controller elsewhere.
 */
`timescale 1ns/10ps
module mtc_csr_top
#(
	parameter int TICK_DIV = mtc_pkg::TIMER_TICK_DIV,
	parameter int FR_DIV   = mtc_pkg::FREE_RUN_DIV
)
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        host_cs_b,
	input  wire logic        host_rd_b,
	input  wire logic        host_wr_b,
	input  wire logic [7:1]  host_addr,
	input  wire logic [15:0] host_data_in,
	output logic      [15:0] host_data_out,
	output logic             host_data_oe,
	input  wire logic        frame_dropped,
	output logic             timer_event,
	output logic             drop_midpoint_event
);
	if (TICK_DIV < 2 || TICK_DIV >= (1 << mtc_pkg::DIV_W))
		$error("TICK_DIV out of range");
	if (FR_DIV < 2 || FR_DIV >= (1 << mtc_pkg::DIV_W))
		$error("FR_DIV out of range");

	localparam logic [mtc_pkg::DIV_W-1:0] TICK_LAST = mtc_pkg::DIV_W'(TICK_DIV - 1);
	localparam logic [mtc_pkg::DIV_W-1:0] FR_LAST   = mtc_pkg::DIV_W'(FR_DIV - 1);

	typedef struct packed
	{
		logic                     run;
		logic [15:0]              preload;
		logic [15:0]              count;
		logic [31:0]              word_order;
		logic [mtc_pkg::DIV_W-1:0] gp_div;
		logic [mtc_pkg::DIV_W-1:0] fr_div;
		logic [31:0]              ticks;
		logic [31:0]              tick_snap;
		logic                     tick_snap_vld;
		logic [31:0]              drops;
		logic [31:0]              drop_snap;
		logic                     drop_snap_vld;
		logic [15:0]              rd_data;
		logic                     timer_evt;
		logic                     mid_evt;
	} mtc_csr_t;

	mtc_csr_t csr_reg;
	mtc_csr_t csr_next;

	mtc_host_if hbus ();

	mtc_host_front u_front
	(
		.mclk     (mclk),
		.rst_b    (rst_b),
		.cs_b     (host_cs_b),
		.rd_b     (host_rd_b),
		.wr_b     (host_wr_b),
		.addr     (host_addr),
		.data_in  (host_data_in),
		.data_out (host_data_out),
		.data_oe  (host_data_oe),
		.bus      (hbus.front)
	);

	// true when the host halfword maps to bits 31-16
	function automatic logic upper_half(input logic a1, input logic [31:0] order);
		upper_half = (order == mtc_pkg::WORD_ORDER_SWAPPED) ? ~a1 : a1;
	endfunction

	function automatic logic [15:0] pick_half(input logic [31:0] val, input logic up);
		pick_half = up ? val[31:16] : val[15:0];
	endfunction

	function automatic logic hits(input logic [7:0] byte_addr, input logic [7:0] ofs);
		hits = (byte_addr[7:2] == ofs[7:2]);
	endfunction

	logic        up;
	logic        rd_drop;
	logic        fr_tick;
	logic        gp_tick;

	always_comb
	begin
		csr_next           = csr_reg;
		csr_next.timer_evt = 1'b0;
		csr_next.mid_evt   = 1'b0;
		// the swap only steers which halfword a host access reaches
		up      = upper_half(hbus.byte_addr[1], csr_reg.word_order);
		rd_drop = hbus.rd_stb && hits(hbus.byte_addr, mtc_pkg::DROPPED_FRAME_OFS);

		// free-running 25 MHz count, no power-state gating exists here
		fr_tick = (csr_reg.fr_div == FR_LAST);
		csr_next.fr_div = fr_tick ? '0 : csr_reg.fr_div + 1'b1;
		if (fr_tick)
			csr_next.ticks = csr_reg.ticks + 32'h0000_0001;

		// host writes
		if (hbus.wr_stb)
		begin
			if (hits(hbus.byte_addr, mtc_pkg::TIMER_CONFIG_OFS))
			begin
				if (up)
				begin
					csr_next.run = hbus.wr_data[mtc_pkg::TIMER_RUN_HI_BIT];
					if (csr_reg.run && !csr_next.run)
						csr_next.preload = mtc_pkg::PRELOAD_ON_HALT;
				end
				else
					csr_next.preload = hbus.wr_data;
			end
			if (hits(hbus.byte_addr, mtc_pkg::HOST_WORD_ORDER_OFS))
			begin
				if (up)
					csr_next.word_order[31:16] = hbus.wr_data;
				else
					csr_next.word_order[15:0] = hbus.wr_data;
			end
		end

		// general purpose timer
		gp_tick = csr_reg.run && (csr_reg.gp_div == TICK_LAST);
		if (!csr_reg.run)
			csr_next.gp_div = '0;
		else
			csr_next.gp_div = gp_tick ? '0 : csr_reg.gp_div + 1'b1;
		if (csr_next.run && !csr_reg.run)
			csr_next.count = csr_next.preload;
		else if (gp_tick)
		begin
			if (csr_reg.count == 16'h0000)
			begin
				csr_next.count     = csr_reg.preload;
				csr_next.timer_evt = 1'b1;
			end
			else
				csr_next.count = csr_reg.count - 16'h0001;
		end

		// dropped frame tally: a drop in the clearing cycle is kept
		if (rd_drop)
			csr_next.drops = frame_dropped ? 32'h0000_0001 : 32'h0000_0000;
		else if (frame_dropped)
		begin
			csr_next.drops = csr_reg.drops + 32'h0000_0001;
			if (csr_reg.drops == mtc_pkg::DROP_MIDPOINT_FROM)
				csr_next.mid_evt = 1'b1;
		end

		// host reads
		if (hbus.rd_stb)
		begin
			csr_next.rd_data = 16'h0000;
			if (hits(hbus.byte_addr, mtc_pkg::TIMER_CONFIG_OFS))
				csr_next.rd_data = pick_half({2'b00, csr_reg.run, 13'h0000, csr_reg.preload},
					up);
			if (hits(hbus.byte_addr, mtc_pkg::TIMER_CURRENT_OFS))
				csr_next.rd_data = pick_half({16'h0000, csr_reg.count}, up);
			if (hits(hbus.byte_addr, mtc_pkg::HOST_WORD_ORDER_OFS))
				csr_next.rd_data = pick_half(csr_reg.word_order, up);
			if (hits(hbus.byte_addr, mtc_pkg::TICK_COUNTER_OFS))
			begin
				if (!csr_reg.tick_snap_vld)
				begin
					// capture all 32 bits so the pair of reads is coherent
					csr_next.tick_snap     = csr_reg.ticks;
					csr_next.tick_snap_vld = 1'b1;
					csr_next.rd_data       = pick_half(csr_reg.ticks, up);
				end
				else
				begin
					csr_next.tick_snap_vld = 1'b0;
					csr_next.rd_data       = pick_half(csr_reg.tick_snap, up);
				end
			end
			if (rd_drop)
			begin
				if (!csr_reg.drop_snap_vld)
				begin
					csr_next.drop_snap     = csr_reg.drops;
					csr_next.drop_snap_vld = 1'b1;
					csr_next.rd_data       = pick_half(csr_reg.drops, up);
				end
				else
				begin
					csr_next.drop_snap_vld = 1'b0;
					csr_next.rd_data       = pick_half(csr_reg.drop_snap, up);
				end
			end
		end
	end

	// the tick counter clears inside the reset itself, well within 160 ns
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			csr_reg            <= '0;
			csr_reg.preload    <= mtc_pkg::PRELOAD_RESET;
			csr_reg.count      <= mtc_pkg::COUNT_RESET;
			csr_reg.word_order <= mtc_pkg::WORD_ORDER_RESET;
		end
		else
			csr_reg <= csr_next;
	end

	assign hbus.rd_data        = csr_reg.rd_data;
	assign timer_event         = csr_reg.timer_evt;
	assign drop_midpoint_event = csr_reg.mid_evt;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	run_load_a: assert property ($rose(csr_reg.run) |-> csr_reg.count == $past(csr_reg.preload))
		else $error("timer start did not load preload");
	halt_hold_a: assert property (!csr_reg.run && !$past(csr_reg.run) |-> $stable(csr_reg.count))
		else $error("halted timer count moved");
	halt_preset_a: assert property ($fell(csr_reg.run) |-> csr_reg.preload == 16'hffff)
		else $error("preload not preset on halt");
	timer_reload_a: assert property (timer_event |-> $past(csr_reg.count) == 16'h0000
		&& csr_reg.count == $past(csr_reg.preload))
		else $error("timer event without reload from zero");
	tick_step_a: assert property ($changed(csr_reg.ticks) |-> csr_reg.ticks == $past(csr_reg.ticks) + 32'h1
		##1 $stable(csr_reg.ticks) [*4])
		else $error("tick counter step or rate wrong");
	drop_count_a: assert property (frame_dropped && !rd_drop |=> csr_reg.drops == $past(csr_reg.drops) + 32'h1)
		else $error("dropped frame not counted");
	drop_clear_a: assert property (rd_drop |=> csr_reg.drops == {31'h0, $past(frame_dropped)})
		else $error("tally not cleared on read");
	drop_mid_a: assert property (drop_midpoint_event |-> $past(csr_reg.drops) == 32'h7fff_ffff
		&& csr_reg.drops == 32'h8000_0000)
		else $error("midpoint event at wrong count");
	tick_pair_a: assert property (hbus.rd_stb && hits(hbus.byte_addr, mtc_pkg::TICK_COUNTER_OFS)
		&& csr_reg.tick_snap_vld |=> csr_reg.rd_data == pick_half($past(csr_reg.tick_snap),
		$past(up)))
		else $error("second tick read not from capture");

	timer_wrap_c: cover property (csr_reg.run ##1 timer_event);
	drop_mid_c: cover property (drop_midpoint_event);
	tick_pair_c: cover property (csr_reg.tick_snap_vld ##[1:200] !csr_reg.tick_snap_vld);
	swap_c: cover property (csr_reg.word_order == 32'hffff_ffff && hbus.rd_stb);
endmodule

// File: rtl/mtc_pkg.sv
/*
 * constants shared by the misc timer/counter register bank: offsets,
 * field positions, reset values and clock-derived counts.
 * assumes a 125 MHz mclk and a 16-bit host bus addressed by bytes.
 */
package mtc_pkg;
	localparam logic [7:0]  TIMER_CONFIG_OFS      = 8'h8c;
	localparam logic [7:0]  TIMER_CURRENT_OFS     = 8'h90;
	localparam logic [7:0]  HOST_WORD_ORDER_OFS   = 8'h98;
	localparam logic [7:0]  TICK_COUNTER_OFS      = 8'h9c;
	localparam logic [7:0]  DROPPED_FRAME_OFS     = 8'ha0;

	localparam int          TIMER_RUN_BIT         = 29;
	localparam int          TIMER_RUN_HI_BIT      = TIMER_RUN_BIT - 16;
	localparam logic [15:0] PRELOAD_RESET         = 16'hffff;
	localparam logic [15:0] PRELOAD_ON_HALT       = 16'hffff;
	localparam logic [15:0] COUNT_RESET           = 16'hffff;
	localparam logic [31:0] WORD_ORDER_RESET      = 32'h0000_0000;
	localparam logic [31:0] WORD_ORDER_SWAPPED    = 32'hffff_ffff;
	localparam logic [31:0] DROP_MIDPOINT_FROM    = 32'h7fff_ffff;

	localparam int          CLK_PERIOD_NS         = 8;
	localparam int          FREE_RUN_PERIOD_NS    = 40;
	localparam int          FREE_RUN_DIV          = FREE_RUN_PERIOD_NS / CLK_PERIOD_NS;
	localparam int          TIMER_TICK_NS         = 1000;
	localparam int          TIMER_TICK_DIV        = TIMER_TICK_NS / CLK_PERIOD_NS;
	localparam int          DIV_W                 = 12;
endpackage

// File: rtl/mtc_host_if.sv
/*
 * carrier between the host pin front end and the register bank.
 * assumes both ends run on mclk; strobes are one-cycle pulses.
 */
`timescale 1ns/10ps
interface mtc_host_if;
	logic        rd_stb;
	logic        wr_stb;
	logic [7:0]  byte_addr;
	logic [15:0] wr_data;
	logic [15:0] rd_data;

	modport front
	(
		output rd_stb, wr_stb, byte_addr, wr_data,
		input  rd_data
	);
	modport csr
	(
		input  rd_stb, wr_stb, byte_addr, wr_data,
		output rd_data
	);
endinterface

// File: rtl/mtc_host_front.sv
/*
 * host pin front end: brings the asynchronous sram-like strobes, address
 * and data into mclk and turns each access into a single strobe.
 * assumes address and write data are stable while a strobe is low.
 */
`timescale 1ns/10ps
module mtc_host_front
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        cs_b,
	input  wire logic        rd_b,
	input  wire logic        wr_b,
	input  wire logic [7:1]  addr,
	input  wire logic [15:0] data_in,
	output logic      [15:0] data_out,
	output logic             data_oe,
	mtc_host_if.front        bus
);
	typedef struct packed
	{
		logic [2:0]       rd_sy;
		logic [2:0]       wr_sy;
		logic [2:0][6:0]  a_sy;
		logic [2:0][15:0] d_sy;
		logic             rd_lvl;
		logic             wr_lvl;
		logic             rd_stb;
		logic             wr_stb;
		logic [7:0]       addr;
		logic [15:0]      wdata;
		logic [15:0]      dout;
		logic             oe;
	} mtc_front_t;

	mtc_front_t front_reg;
	mtc_front_t front_next;

	always_comb
	begin
		front_next        = front_reg;
		front_next.rd_sy  = {front_reg.rd_sy[1:0], ~cs_b & ~rd_b};
		front_next.wr_sy  = {front_reg.wr_sy[1:0], ~cs_b & ~wr_b};
		front_next.a_sy   = {front_reg.a_sy[1:0], addr};
		front_next.d_sy   = {front_reg.d_sy[1:0], data_in};
		// a level only counts once the last two stages agree
		if (front_reg.rd_sy[1] == front_reg.rd_sy[2])
			front_next.rd_lvl = front_reg.rd_sy[2];
		if (front_reg.wr_sy[1] == front_reg.wr_sy[2])
			front_next.wr_lvl = front_reg.wr_sy[2];
		front_next.rd_stb = front_next.rd_lvl & ~front_reg.rd_lvl;
		front_next.wr_stb = front_next.wr_lvl & ~front_reg.wr_lvl;
		if (front_next.rd_stb || front_next.wr_stb)
		begin
			front_next.addr  = {front_reg.a_sy[2], 1'b0};
			front_next.wdata = front_reg.d_sy[2];
		end
		front_next.oe   = front_reg.rd_lvl;
		front_next.dout = front_reg.rd_lvl ? bus.rd_data : 16'h0000;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			front_reg <= '0;
		else
			front_reg <= front_next;
	end

	assign bus.rd_stb    = front_reg.rd_stb;
	assign bus.wr_stb    = front_reg.wr_stb;
	assign bus.byte_addr = front_reg.addr;
	assign bus.wr_data   = front_reg.wdata;
	assign data_out      = front_reg.dout;
	assign data_oe       = front_reg.oe;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	rd_strobe_once_a: assert property (front_reg.rd_stb |=> !front_reg.rd_stb)
		else $error("read strobe longer than one cycle");
	oe_follows_a: assert property ($rose(front_reg.rd_lvl) |=> front_reg.oe)
		else $error("data enable did not follow read level");
endmodule

// File: verification/mtc_host_model.sv
/*
 * host processor model for the sram-like 16-bit bus of the register bank.
 * assumes mclk is the device clock; one access per strobe low period.
 */
`timescale 1ns/10ps
module mtc_host_model
(
	input  wire logic        mclk,
	output logic             cs_b,
	output logic             rd_b,
	output logic             wr_b,
	output logic [7:1]       addr,
	output logic [15:0]      data_in,
	input  wire logic [15:0] data_out
);
	initial
	begin
		cs_b = 1'b1;
		rd_b = 1'b1;
		wr_b = 1'b1;
		addr = 7'h00;
		data_in = 16'h5a5a;
	end

	// strobe held 8 cycles so the synced level is taken and read data settles
	task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] wd,
		output logic [15:0] rd);
		@(posedge mclk);
		cs_b <= 1'b0;
		rd_b <= wr;
		wr_b <= !wr;
		addr <= a[7:1];
		data_in <= wr ? wd : ~data_in;
		repeat (8) @(posedge mclk);
		rd = data_out;
		cs_b <= 1'b1;
		rd_b <= 1'b1;
		wr_b <= 1'b1;
		// released bus shows no stale value
		data_in <= ~data_in;
		addr <= ~a[7:1];
		repeat (6) @(posedge mclk);
	endtask
endmodule

// File: verification/misc_timer_counter_csrs_test.sv
/*
 * self-checking bench for the misc timer and counter register bank.
 * assumes mtc_host_model drives the host pins; timer tick shortened to 4.
 */
`timescale 1ns/10ps
module misc_timer_counter_csrs_test;
	localparam int TD = 4;
	logic        mclk;
	logic        rst_b;
	logic        cs_b;
	logic        rd_b;
	logic        wr_b;
	logic [7:1]  addr;
	logic [15:0] din;
	logic [15:0] dout;
	logic        doe;
	logic        fd;
	logic        tev;
	logic        mev;
	int          err_count;
	int          cmp_count;
	int          cyc;
	int          rel;
	int          mev_cnt;

	mtc_csr_top #(.TICK_DIV(TD)) i_mtc_csr_top
	(
		.mclk                (mclk),
		.rst_b               (rst_b),
		.host_cs_b           (cs_b),
		.host_rd_b           (rd_b),
		.host_wr_b           (wr_b),
		.host_addr           (addr),
		.host_data_in        (din),
		.host_data_out       (dout),
		.host_data_oe        (doe),
		.frame_dropped       (fd),
		.timer_event         (tev),
		.drop_midpoint_event (mev)
	);

	mtc_host_model i_mtc_host_model
	(
		.mclk     (mclk),
		.cs_b     (cs_b),
		.rd_b     (rd_b),
		.wr_b     (wr_b),
		.addr     (addr),
		.data_in  (din),
		.data_out (dout)
	);

	always #4 mclk = ~mclk;

	task automatic results;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			results;
		end
	end

	// every midpoint pulse after reset is counted; no scenario can reach the midpoint
	always @(posedge mclk)
	begin
		if (rst_b && mev !== 1'b0)
			mev_cnt++;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		i_mtc_host_model.access(1'b0, a, 16'h0000, v);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] v;
		i_mtc_host_model.access(1'b1, a, d, v);
	endtask

	// cycles until the next timer event, 300 if none comes
	task automatic wait_ev(output int n);
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (tev !== 1'b1 && n < 300);
	endtask

	task automatic test_reset;
		logic [15:0] v;
		// the enable must stand while the read level is held, and drop after release
		fork
			rd(8'h8c, v);
			begin
				repeat (7) @(posedge mclk);
				check(32'(doe), 32'd1);
			end
		join
		check(v, 16'hffff);
		check(32'(doe), 32'd0);
		check(32'(dout), 32'd0);
		rd(8'h8e, v);
		check(v, 16'h0000);
		wr(8'h90, 16'h1234);
		rd(8'h90, v);
		check(v, 16'hffff);
		rd(8'h98, v);
		check(v, 16'h0000);
		rd(8'ha0, v);
		check(v, 16'h0000);
		rd(8'ha2, v);
		check(v, 16'h0000);
		wr(8'h94, 16'h1234);
		rd(8'h94, v);
		check(v, 16'h0000);
		$display("test reset done");
	endtask

	task automatic test_timer;
		logic [15:0] v;
		int          n;
		wr(8'h8c, 16'h0003);
		wr(8'h8e, 16'h2000);
		rd(8'h8c, v);
		check(v, 16'h0003);
		wait_ev(n);
		wait_ev(n);
		check(32'(n), 32'(TD * 4));
		wr(8'h8e, 16'h0000);
		wait_ev(n);
		check(32'(n), 32'd300);
		rd(8'h8c, v);
		check(v, 16'hffff);
		rd(8'h90, v);
		check(32'(v <= 16'h0003), 32'd1);
		$display("test timer done");
	endtask

	task automatic test_swap;
		logic [15:0] v;
		wr(8'h98, 16'hffff);
		wr(8'h9a, 16'hffff);
		rd(8'h8c, v);
		check(v, 16'h0000);
		rd(8'h8e, v);
		check(v, 16'hffff);
		wr(8'h98, 16'h0000);
		wr(8'h98, 16'h0000);
		rd(8'h9a, v);
		check(v, 16'h0000);
		rd(8'h8c, v);
		check(v, 16'hffff);
		$display("test swap done");
	endtask

	task automatic test_ticks;
		logic [15:0] a;
		logic [15:0] b;
		logic [31:0] v1;
		logic [31:0] v2;
		int          c1;
		int          c2;
		rd(8'h9c, a);
		repeat (100) @(posedge mclk);
		rd(8'h9c, b);
		check(b, a);
		c1 = cyc;
		rd(8'h9c, a);
		rd(8'h9e, b);
		v1 = {b, a};
		check(32'(v1 + 2 - (c1 - rel + 4) / 5 <= 4), 32'd1);
		repeat (400) @(posedge mclk);
		c2 = cyc;
		rd(8'h9c, a);
		rd(8'h9e, b);
		v2 = {b, a};
		check(32'(v2 - v1 + 1 - (c2 - c1) / 5 <= 2), 32'd1);
		$display("test ticks done");
	endtask

	task automatic test_drops;
		logic [15:0] v;
		repeat (3)
		begin
			@(posedge mclk);
			fd <= 1'b1;
			@(posedge mclk);
			fd <= 1'b0;
		end
		rd(8'ha0, v);
		check(v, 16'h0003);
		rd(8'ha2, v);
		check(v, 16'h0000);
		rd(8'ha0, v);
		check(v, 16'h0000);
		check(32'(mev_cnt), 32'd0);
		$display("test drops done");
	endtask

	initial
	begin
		mclk = 1'b0;
		rst_b = 1'b0;
		fd = 1'b0;
		err_count = 0;
		cmp_count = 0;
		cyc = 0;
		mev_cnt = 0;
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		rel = cyc;
		test_reset;
		test_timer;
		test_swap;
		test_ticks;
		test_drops;
		results;
	end
endmodule
